/* core/pdci_core.sv */
// pdci_core.sv - device side of the packet dram: packet decode, banks, write buffer, data lanes
// assumes: pins synchronous to CLK_I; controller keeps neighbour banks apart and spaces reads
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "pdci_map.svh"
module pdci_core (
   input  wire logic        CLK_I,            // clock, both receive and transmit side
   input  wire logic        SYS_RST_I,        // async reset, high
   input  wire logic [2:0]  ROW_I,            // row request pins
   input  wire logic [4:0]  COL_I,            // column request pins
   input  wire logic [7:0]  DATA_LANE_A_I,    // data lane a in
   input  wire logic [7:0]  DATA_LANE_B_I,    // data lane b in
   output logic      [7:0]  DATA_LANE_A_O,    // data lane a out
   output logic      [7:0]  DATA_LANE_B_O,    // data lane b out
   output logic             DATA_LANE_A_OE_O, // lane a driven
   output logic             DATA_LANE_B_OE_O, // lane b driven
   input  wire logic [3:0]  REG_ADDR_I,       // register address
   input  wire logic [31:0] REG_WDATA_I,      // register write data
   input  wire logic        REG_WR_I,         // write strobe
   input  wire logic        REG_RD_I,         // read strobe
   output logic      [31:0] REG_RDATA_O       // read data, cycle after strobe
);

   // ==========================================
   // sizes
   localparam int ROW_W  = `PDCI_ROW_PINS * `PDCI_BEATS;
   localparam int COL_W  = `PDCI_COL_PINS * `PDCI_BEATS;
   localparam int DAT_W  = 2 * `PDCI_LANE_W * `PDCI_BEATS;
   localparam int WORDS  = `PDCI_BANKS * `PDCI_ROWS * `PDCI_DUALOCTS;
   localparam int ADDR_W = $clog2(WORDS);

   // ==========================================
   // state
   logic [4:0]                 device_identifier;
   logic [8:0]                 refresh_row_counter;
   logic [31:0]                open;
   logic [31:0]                next_open;
   logic [8:0]                 open_row [0:`PDCI_BANKS-1];
   logic                       conflict;
   pdci_pkg::pdci_wbuf_type    wbuf;
   logic                       wr_pend;
   logic [4:0]                 wr_bank;
   logic [5:0]                 wr_col;
   logic                       pre_pend;
   logic [4:0]                 pre_bank;
   logic                       rd_load;
   pdci_pkg::pdci_dualoct_type rd_word;
   logic [DAT_W-1:0]           core_mem [0:WORDS-1];

   // ==========================================
   // packet collectors
   logic                       row_done;
   logic [ROW_W-1:0]           row_word;
   logic                       col_done;
   logic [COL_W-1:0]           col_word;
   logic                       wd_done;
   logic [DAT_W-1:0]           wd_word;
   wire                        row_start = ROW_I[2] | ROW_I[1];
   wire                        col_start = COL_I[4];
   wire  [15:0]                data_pins = {DATA_LANE_B_I, DATA_LANE_A_I};
   wire                        self_wr;
   wire                        status_clr;

   // row and column groups run side by side, neither waits on the other
   pdci_deser #(
      .PIN_W (`PDCI_ROW_PINS),
      .BEATS (`PDCI_BEATS)
   ) u_row_deser (
      .clk_i   (CLK_I),
      .rst_i   (SYS_RST_I),
      .start_i (row_start),
      .pins_i  (ROW_I),
      .done_o  (row_done),
      .word_o  (row_word)
   );

   pdci_deser #(
      .PIN_W (`PDCI_COL_PINS),
      .BEATS (`PDCI_BEATS)
   ) u_col_deser (
      .clk_i   (CLK_I),
      .rst_i   (SYS_RST_I),
      .start_i (col_start),
      .pins_i  (COL_I),
      .done_o  (col_done),
      .word_o  (col_word)
   );

   // write data starts in the beat right after its column packet completes
   pdci_deser #(
      .PIN_W (2 * `PDCI_LANE_W),
      .BEATS (`PDCI_BEATS)
   ) u_wd_deser (
      .clk_i   (CLK_I),
      .rst_i   (SYS_RST_I),
      .start_i (self_wr),
      .pins_i  (data_pins),
      .done_o  (wd_done),
      .word_o  (wd_word)
   );

   // ==========================================
   // data path split: beat k carries byte k of each path
   pdci_pkg::pdci_dualoct_type wd_dual;
   genvar gk;
   generate
      for (gk = 0; gk < `PDCI_BEATS; gk++) begin : g_beat
         assign wd_dual.path_a[8*gk +: 8] = wd_word[DAT_W-9-16*gk -: 8];
         assign wd_dual.path_b[8*gk +: 8] = wd_word[DAT_W-1-16*gk -: 8];
      end
   endgenerate

   // ==========================================
   // row decode
   pdci_pkg::pdci_row_pkt_type row_pkt;
   assign row_pkt = pdci_pkg::pdci_row_pkt_type'(row_word);

   wire        row_bcast  = row_pkt.frame_true & row_pkt.frame_false;
   wire        row_single = row_pkt.frame_true ^ row_pkt.frame_false;
   wire        row_id_hit = device_identifier == {row_pkt.frame_true, row_pkt.dev};
   wire        row_match  = row_done & (row_bcast | (row_single & row_id_hit));
   wire        row_act    = row_match & row_pkt.select;
   wire        row_op     = row_match & ~row_pkt.select;
   wire [10:0] rop        = row_pkt.payload[10:0];
   wire        row_pre    = row_op & (rop == `PDCI_ROP_PRE);
   wire        row_refa   = row_op & (rop == `PDCI_ROP_REFA);
   wire [4:0]  act_bank   = row_pkt.bank;
   wire        act_any    = row_act | row_refa;
   wire [8:0]  act_row    = row_refa ? refresh_row_counter : row_pkt.payload[8:0];

   // edge banks own one sense amp alone; the rest share with a neighbour
   wire        lo_shared  = (act_bank != 5'h00) && (act_bank != 5'h10);
   wire        hi_shared  = (act_bank != 5'h0F) && (act_bank != 5'h1F);
   wire        nbr_lo     = lo_shared && open[act_bank - 5'h01];
   wire        nbr_hi     = hi_shared && open[act_bank + 5'h01];
   wire        act_ok     = act_any & ~open[act_bank] & ~nbr_lo & ~nbr_hi;
   wire        act_clash  = act_any & ~act_ok;
   wire        refa_inc   = row_refa & (act_bank == 5'h1F);

   // ==========================================
   // column decode
   pdci_pkg::pdci_col_op_type   col_op;
   pdci_pkg::pdci_mask_pkt_type mask_pkt;
   pdci_pkg::pdci_ext_pkt_type  ext_pkt;
   assign col_op   = pdci_pkg::pdci_col_op_type'(col_word[COL_W-1 -: `PDCI_COL_OP_W]);
   assign mask_pkt = pdci_pkg::pdci_mask_pkt_type'(col_word[`PDCI_COMP_W-1:0]);
   assign ext_pkt  = pdci_pkg::pdci_ext_pkt_type'(col_word[`PDCI_COMP_W-1:0]);

   wire [2:0]  kind      = col_op.opcode[2:0];
   wire        with_pre  = col_op.opcode[`PDCI_CMD_PRE_BIT];
   wire        is_rd     = kind == `PDCI_CMD_RD;
   wire        is_wr     = kind == `PDCI_CMD_WR;
   wire        is_noop   = kind == `PDCI_CMD_NOOP;
   wire        known     = is_rd | is_wr | is_noop;
   wire        col_match = col_done & (col_op.dev == device_identifier);
   wire        self_rd   = col_match & is_rd & open[col_op.bank];
   assign      self_wr   = col_match & is_wr;
   wire        col_pre   = col_match & known & with_pre;

   // a read to this device holds the buffer; any other known command drains it
   wire        retire    = wbuf.valid & col_done & known & ~(col_match & is_rd);
   wire        ret_open  = open[wbuf.bank];
   wire        ret_go    = retire & ret_open;
   // mask packet belongs to the earlier write now sitting in the buffer
   wire [15:0] ret_be    = mask_pkt.mask_select ? {mask_pkt.mask_b, mask_pkt.mask_a} : 16'hFFFF;

   // extended packet only rides on a read or an unmasked write
   wire        ext_ok    = col_done & ~ext_pkt.mask_select & (is_rd | is_wr);
   wire        ext_pre   = ext_ok & (ext_pkt.dev == device_identifier) & (ext_pkt.ext_op == `PDCI_EXT_PRE);

   // ==========================================
   // core addressing
   wire [ADDR_W-1:0] rd_addr  = {col_op.bank, open_row[col_op.bank], col_op.col};
   wire [ADDR_W-1:0] ret_addr = {wbuf.bank, open_row[wbuf.bank], wbuf.col};

   // sense amps are folded into the core array; an open bank reads and writes its row
   // directly, which keeps half-row buffers out of the model
   always_ff @(posedge CLK_I) begin
      if (ret_go) begin
         for (int k = 0; k < `PDCI_BYTES; k++) begin
            if (ret_be[k]) begin
               core_mem[ret_addr][8*k +: 8] <= wbuf.data[8*k +: 8];
            end
         end
      end
      if (self_rd) begin
         rd_word <= pdci_pkg::pdci_dualoct_type'(core_mem[rd_addr]);
      end
   end

   // ==========================================
   // bank open state
   always_comb begin
      next_open = open;
      if (row_pre) begin
         next_open[act_bank] = 1'b0;
      end
      if (ext_pre) begin
         next_open[ext_pkt.bank] = 1'b0;
      end
      if (pre_pend) begin
         next_open[pre_bank] = 1'b0;
      end
      if (act_ok) begin
         next_open[act_bank] = 1'b1;
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         open     <= '0;
         pre_pend <= 1'b0;
         pre_bank <= '0;
         conflict <= 1'b0;
      end else begin
         open     <= next_open;
         pre_pend <= col_pre; // closes one cycle after the column access
         pre_bank <= col_op.bank;
         conflict <= act_clash | (conflict & ~status_clr);
      end
   end

   always_ff @(posedge CLK_I) begin
      if (act_ok) begin
         open_row[act_bank] <= act_row;
      end
   end

   // ==========================================
   // write buffer
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         wbuf    <= '0;
         wr_pend <= 1'b0;
         wr_bank <= '0;
         wr_col  <= '0;
      end else begin
         if (self_wr) begin
            wr_pend <= 1'b1;
            wr_bank <= col_op.bank;
            wr_col  <= col_op.col;
         end else if (wd_done) begin
            wr_pend <= 1'b0;
         end
         // fresh data wins over a drain of the old contents in the same cycle
         if (wd_done) begin
            wbuf <= '{valid: 1'b1, bank: wr_bank, col: wr_col, data: wd_dual};
         end else if (retire) begin
            wbuf.valid <= 1'b0;
         end
      end
   end

   // ==========================================
   // read transmit
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rd_load <= 1'b0;
      end else begin
         rd_load <= self_rd;
      end
   end

   logic tx_drive;

   pdci_ser #(
      .PATH_W (`PDCI_PATH_W),
      .LANE_W (`PDCI_LANE_W)
   ) u_tx (
      .clk_i    (CLK_I),
      .rst_i    (SYS_RST_I),
      .load_i   (rd_load),
      .path_a_i (rd_word.path_a),
      .path_b_i (rd_word.path_b),
      .lane_a_o (DATA_LANE_A_O),
      .lane_b_o (DATA_LANE_B_O),
      .drive_o  (tx_drive)
   );

   assign DATA_LANE_A_OE_O = tx_drive;
   assign DATA_LANE_B_OE_O = tx_drive;

   // ==========================================
   // register port
   wire        reg_wr_id   = REG_WR_I & (REG_ADDR_I == `PDCI_REG_ID);
   wire        reg_wr_ref  = REG_WR_I & (REG_ADDR_I == `PDCI_REG_REFRESH);
   assign      status_clr  = REG_WR_I & (REG_ADDR_I == `PDCI_REG_STATUS) & REG_WDATA_I[`PDCI_ST_CONFLICT];
   wire [31:0] status_word = {29'h0, wr_pend, conflict, wbuf.valid};
   wire [31:0] reg_mux     = (REG_ADDR_I == `PDCI_REG_ID)      ? {27'h0, device_identifier}   :
                             (REG_ADDR_I == `PDCI_REG_REFRESH) ? {23'h0, refresh_row_counter} :
                             (REG_ADDR_I == `PDCI_REG_STATUS)  ? status_word                  :
                             (REG_ADDR_I == `PDCI_REG_OPEN)    ? open                         :
                                                                 32'h0;

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         device_identifier   <= `PDCI_RST_ID;
         refresh_row_counter <= `PDCI_RST_REFRESH;
         REG_RDATA_O         <= '0;
      end else begin
         if (reg_wr_id) begin
            device_identifier <= REG_WDATA_I[4:0];
         end
         // refresh stepping beats a software write in the same cycle
         if (refa_inc) begin
            refresh_row_counter <= refresh_row_counter + 9'h001;
         end else if (reg_wr_ref) begin
            refresh_row_counter <= REG_WDATA_I[8:0];
         end
         REG_RDATA_O <= REG_RD_I ? reg_mux : 32'h0;
      end
   end

endmodule : pdci_core

/* core/pdci_deser.sv */
// pdci_deser.sv - collects a fixed number of beats from a pin group into one word
// assumes: start_i is high in the first beat; first beat lands in the top bits
`timescale 1ns/100ps
module pdci_deser #(
   parameter int PIN_W = 3,
   parameter int BEATS = 8
) (
   input  wire logic                   clk_i,   // clock
   input  wire logic                   rst_i,   // async reset, high
   input  wire logic                   start_i, // first beat present
   input  wire logic [PIN_W-1:0]       pins_i,  // pin group
   output logic                        done_o,  // word complete pulse
   output logic [PIN_W*BEATS-1:0]      word_o   // collected word
);
   localparam int W   = PIN_W * BEATS;
   localparam int CW  = $clog2(BEATS);

   pdci_pkg::pdci_des_state_type state;
   logic [W-1:0]                  shift;
   logic [CW-1:0]                 cnt;
   wire  [W-1:0]                  next_shift = {shift[W-PIN_W-1:0], pins_i};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state  <= pdci_pkg::PDCI_DES_IDLE;
         shift  <= '0;
         cnt    <= '0;
         done_o <= 1'b0;
         word_o <= '0;
      end else begin
         done_o <= 1'b0;
         case (state)
            pdci_pkg::PDCI_DES_IDLE: begin
               if (start_i) begin
                  shift <= {{(W-PIN_W){1'b0}}, pins_i};
                  cnt   <= CW'(1);
                  state <= pdci_pkg::PDCI_DES_COLLECT;
               end
            end
            pdci_pkg::PDCI_DES_COLLECT: begin
               shift <= next_shift;
               cnt   <= cnt + CW'(1);
               if (cnt == CW'(BEATS-1)) begin
                  done_o <= 1'b1;
                  word_o <= next_shift;
                  state  <= pdci_pkg::PDCI_DES_IDLE;
               end
            end
            default: state <= pdci_pkg::PDCI_DES_IDLE;
         endcase
      end
   end

endmodule : pdci_deser

/* core/pdci_map.svh */
// pdci_map.svh - offsets, field widths, opcodes and reset values of the packet dram interface
// assumes: included by bare name; opcode values are local encodings of this core
//
// Notes on behaviour
// - three row pins over eight beats form a 24-bit activate or operation packet
// - five column pins form a 23-bit column packet plus 17-bit companion packet
// - row pins and column pins are decoded by independent collectors
// - a five-bit identifier, software written, sets the device address
// - a nine-bit counter holds the row that the next refresh activates
// - read data leaves on the transmit clock, packets and write data arrive on receive clock; here both sides run on CLK_I
// - sixteen data pins map to two 64-bit paths at one eighth pin rate
// - core is two sets of sixteen banks, 512 rows, 64 dualocts of 16 bytes
// - neighbour banks share sense amps except banks 0, 15, 16, 31
// - a sense amp holds half a row of an associated bank, 256 bytes a lane
// - activate loads the addressed row of the bank into its sense amps
// - precharge releases the bank's two sense amps for reuse
// - a read puts one addressed dualoct onto both data lanes
// - a write captures the dualoct with its bank and column into the write buffer
// - buffered data retires, masked, on a later known column command other than a read to this device
// - a read to this device leaves the write buffer untouched
// - precharge variants of noop, read, write close the bank after the operation; a write here closes it before its data is buffered
// - extended packet is honoured only beside a read or an unmasked write
// - both frame bits broadcast, none means idle, one gives the fifth address bit
// - row select bit one marks activate, zero marks operation packet
// - mask-select one gives a bytemask packet, zero an extended packet
// - mask bit one writes its byte; bit zero governs the earliest byte
`ifndef PDCI_MAP_SVH
`define PDCI_MAP_SVH

// ==========================================
// pins and packet sizes
`define PDCI_ROW_PINS     3
`define PDCI_COL_PINS     5
`define PDCI_LANE_W       8
`define PDCI_BEATS        8
`define PDCI_PATH_W       64
`define PDCI_COL_OP_W     23
`define PDCI_COMP_W       17
`define PDCI_BYTES        16

// ==========================================
// core geometry
`define PDCI_BANKS        32
`define PDCI_ROWS         512
`define PDCI_DUALOCTS     64

// ==========================================
// opcodes; column bit 3 asks for precharge afterwards
`define PDCI_CMD_NOOP     3'h0
`define PDCI_CMD_WR       3'h1
`define PDCI_CMD_RD       3'h2
`define PDCI_CMD_PRE_BIT  3
`define PDCI_ROP_PRE      11'h001
`define PDCI_ROP_REFA     11'h002
`define PDCI_EXT_PRE      5'h01

// ==========================================
// register offsets, status bits, reset values
`define PDCI_REG_ID       4'h0
`define PDCI_REG_REFRESH  4'h4
`define PDCI_REG_STATUS   4'h8
`define PDCI_REG_OPEN     4'hC
`define PDCI_ST_WBUF      0
`define PDCI_ST_CONFLICT  1
`define PDCI_ST_WPEND     2
`define PDCI_RST_ID       5'h00
`define PDCI_RST_REFRESH  9'h000

`endif

/* core/pdci_pkg.sv */
// pdci_pkg.sv - packet and buffer types of the packet dram interface
// assumes: field order is first beat in the top bits
package pdci_pkg;

   typedef struct packed {
      logic        frame_true;
      logic        frame_false;
      logic [3:0]  dev;
      logic        select;
      logic [4:0]  bank;
      logic [11:0] payload;
   } pdci_row_pkt_type;

   typedef struct packed {
      logic       start;
      logic [4:0] dev;
      logic [4:0] bank;
      logic [5:0] col;
      logic [3:0] opcode;
      logic [1:0] rsv;
   } pdci_col_op_type;

   typedef struct packed {
      logic       mask_select;
      logic [7:0] mask_a;
      logic [7:0] mask_b;
   } pdci_mask_pkt_type;

   typedef struct packed {
      logic       mask_select;
      logic [4:0] dev;
      logic [4:0] bank;
      logic [4:0] ext_op;
      logic       rsv;
   } pdci_ext_pkt_type;

   typedef struct packed {
      logic [63:0] path_b;
      logic [63:0] path_a;
   } pdci_dualoct_type;

   typedef struct packed {
      logic             valid;
      logic [4:0]       bank;
      logic [5:0]       col;
      pdci_dualoct_type data;
   } pdci_wbuf_type;

   typedef enum logic {PDCI_DES_IDLE, PDCI_DES_COLLECT} pdci_des_state_type;

endpackage : pdci_pkg

/* core/pdci_ser.sv */
// pdci_ser.sv - drives two parallel paths out one byte per lane per beat
// assumes: byte 0 of each path leaves first; a new load waits for the last beat
`timescale 1ns/100ps
module pdci_ser #(
   parameter int PATH_W = 64,
   parameter int LANE_W = 8
) (
   input  wire logic              clk_i,    // clock
   input  wire logic              rst_i,    // async reset, high
   input  wire logic              load_i,   // start a burst
   input  wire logic [PATH_W-1:0] path_a_i, // lane a path
   input  wire logic [PATH_W-1:0] path_b_i, // lane b path
   output logic      [LANE_W-1:0] lane_a_o, // lane a beat
   output logic      [LANE_W-1:0] lane_b_o, // lane b beat
   output logic                   drive_o   // lanes driven
);
   localparam int BEATS = PATH_W / LANE_W;
   localparam int CW    = $clog2(BEATS + 1);

   logic [PATH_W-1:0] sh_a;
   logic [PATH_W-1:0] sh_b;
   logic [CW-1:0]     cnt;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sh_a     <= '0;
         sh_b     <= '0;
         cnt      <= '0;
         lane_a_o <= '0;
         lane_b_o <= '0;
         drive_o  <= 1'b0;
      end else if (load_i) begin
         lane_a_o <= path_a_i[LANE_W-1:0];
         lane_b_o <= path_b_i[LANE_W-1:0];
         sh_a     <= path_a_i >> LANE_W;
         sh_b     <= path_b_i >> LANE_W;
         cnt      <= CW'(BEATS - 1);
         drive_o  <= 1'b1;
      end else if (cnt != '0) begin
         lane_a_o <= sh_a[LANE_W-1:0];
         lane_b_o <= sh_b[LANE_W-1:0];
         sh_a     <= sh_a >> LANE_W;
         sh_b     <= sh_b >> LANE_W;
         cnt      <= cnt - CW'(1);
      end else begin
         drive_o  <= 1'b0;
      end
   end

endmodule : pdci_ser

/* test/pdci_chk.sv */
// pdci_chk.sv - port assertions for the packet dram core
// assumes: bound to pdci_core, one clock, async reset high
`timescale 1ns/100ps
module pdci_chk (
   input wire logic        CLK_I,            // clock
   input wire logic        SYS_RST_I,        // reset
   input wire logic [4:0]  COL_I,            // column pins
   input wire logic        DATA_LANE_A_OE_O, // lane a on
   input wire logic        DATA_LANE_B_OE_O, // lane b on
   input wire logic [3:0]  REG_ADDR_I,       // address
   input wire logic [31:0] REG_WDATA_I,      // write data
   input wire logic        REG_WR_I,         // write
   input wire logic        REG_RD_I,         // read
   input wire logic [31:0] REG_RDATA_O       // read data
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // ==========
   // register port
   sequence id_wr;
      REG_WR_I && REG_ADDR_I == 4'h0;
   endsequence
   sequence id_rd;
      REG_RD_I && REG_ADDR_I == 4'h0;
   endsequence
   AST_ID_KEEP: assert property (id_wr ##1 id_rd |=> REG_RDATA_O == ($past(REG_WDATA_I, 2) & 32'h1F))
      else $error("id readback wrong");
   AST_REF_W: assert property (REG_RD_I && REG_ADDR_I == 4'h4 |=> REG_RDATA_O[31:9] == 23'h0)
      else $error("refresh wider than nine bits");
   AST_ST_W: assert property (REG_RD_I && REG_ADDR_I == 4'h8 |=> REG_RDATA_O[31:3] == 29'h0)
      else $error("status spare bits set");
   AST_UNMAP: assert property (REG_RD_I && REG_ADDR_I[1:0] != 2'h0 |=> REG_RDATA_O == 32'h0)
      else $error("unmapped read not zero");
   AST_RD_IDLE: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
      else $error("read data outside its cycle");
   // ==========
   // data lanes
   AST_OE_LEN: assert property ($rose(DATA_LANE_A_OE_O) |-> DATA_LANE_A_OE_O[*8] ##1 !DATA_LANE_A_OE_O)
      else $error("burst not eight beats");
   AST_OE_PAIR: assert property (DATA_LANE_A_OE_O == DATA_LANE_B_OE_O)
      else $error("lanes driven apart");
   AST_OE_CAUSE: assert property ($rose(DATA_LANE_A_OE_O) |-> $past(COL_I[4], 10))
      else $error("burst without column packet");
endmodule : pdci_chk
bind pdci_core pdci_chk u_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .COL_I(COL_I),
   .DATA_LANE_A_OE_O(DATA_LANE_A_OE_O), .DATA_LANE_B_OE_O(DATA_LANE_B_OE_O), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O));

/* test/pdci_ctl.sv */
// pdci_ctl.sv - channel controller model: packets, write data, read capture
// assumes: tasks called from tb; lane inputs are the resolved wires
`timescale 1ns/100ps
module pdci_ctl (
   input  wire logic       clk_i,    // clock
   input  wire logic [7:0] lane_a_i, // lane a wire
   input  wire logic [7:0] lane_b_i, // lane b wire
   input  wire logic       oe_i,     // device drives
   output logic [2:0]      row_o,    // row pins
   output logic [4:0]      col_o,    // column pins
   output logic [7:0]      lane_a_o, // lane a drive
   output logic [7:0]      lane_b_o, // lane b drive
   output pdci_pkg::pdci_dualoct_type rd_o // last burst
);
   initial {row_o, col_o, lane_a_o, lane_b_o} = '0;
   // byte 0 comes first, so shifting down leaves it lowest
   always @(posedge clk_i)
      if (oe_i) rd_o <= {lane_b_i, rd_o.path_b[63:8], lane_a_i, rd_o.path_a[63:8]};
   task row(input logic [23:0] w);
      for (int k = 0; k < 9; k++) begin
         @(posedge clk_i);
         row_o <= (k < 8) ? w[23-3*k -: 3] : 3'h0;
      end
   endtask : row
   task col(input logic [39:0] w, input logic wd, input pdci_pkg::pdci_dualoct_type d);
      for (int k = 0; k < 17; k++) begin
         @(posedge clk_i);
         col_o <= (k < 8) ? w[39-5*k -: 5] : 5'h0;
         if (wd && k >= 8 && k < 16) begin
            lane_a_o <= d.path_a[8*(k-8) +: 8];
            lane_b_o <= d.path_b[8*(k-8) +: 8];
         end else begin
            // idle lanes toggle so no stale byte looks valid
            lane_a_o <= ~lane_a_o;
            lane_b_o <= ~lane_b_o;
         end
      end
   endtask : col
endmodule : pdci_ctl

/* test/tb.sv */
// tb.sv - self-checking bench for the packet dram core
// assumes: pdci_ctl stands for the controller; registers over the plain port
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; $display("Error %s exp %h got %h", n, e, s); end end
module tb;
   logic clk, rst, wr, rs, a_oe, b_oe;
   logic [3:0] ra;
   logic [31:0] wd, rdat;
   logic [2:0] row;
   logic [4:0] col;
   logic [7:0] a_o, b_o, a_c, b_c, a_w, b_w;
   pdci_pkg::pdci_dualoct_type rd_q;
   int err_count = 0;
   int compares = 0;
   localparam logic [127:0] D1 = {64'hB7B6B5B4B3B2B1B0, 64'hA7A6A5A4A3A2A1A0};
   localparam logic [127:0] D2 = {64'hD7D6D5D4D3D2D1D0, 64'hC7C6C5C4C3C2C1C0};
   localparam logic [127:0] DM = {64'hD7B6B5B4B3B2B1B0, 64'hA7A6A5A4A3A2A1C0};
   logic [35:0] tab [5] = '{{4'h0, 32'h0}, {4'h4, 32'h0}, {4'h8, 32'h0}, {4'hC, 32'h0}, {4'h2, 32'h0}};
   assign a_w = a_oe ? a_o : a_c;
   assign b_w = b_oe ? b_o : b_c;
   pdci_core dut (.CLK_I(clk), .SYS_RST_I(rst), .ROW_I(row), .COL_I(col), .DATA_LANE_A_I(a_w),
      .DATA_LANE_B_I(b_w), .DATA_LANE_A_O(a_o), .DATA_LANE_B_O(b_o), .DATA_LANE_A_OE_O(a_oe),
      .DATA_LANE_B_OE_O(b_oe), .REG_ADDR_I(ra), .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rs),
      .REG_RDATA_O(rdat));
   pdci_ctl ctl (.clk_i(clk), .lane_a_i(a_w), .lane_b_i(b_w), .oe_i(a_oe), .row_o(row), .col_o(col),
      .lane_a_o(a_c), .lane_b_o(b_c), .rd_o(rd_q));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========
   // tasks
   // a write strobe is dropped by the read that always follows it
   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      {wr, rs, ra, wd} <= {2'b10, a, d};
   endtask : wr_reg
   task rd(input logic [3:0] a, input logic [31:0] e, input string n);
      @(posedge clk);
      {wr, rs, ra} <= {2'b01, a};
      @(posedge clk);
      rs <= 1'b0;
      #1 `CHK(n, e, rdat)
   endtask : rd
   task tdone(input string n);
      $display("test %s done", n);
   endtask : tdone
   task close_out();
      $display("checks %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out
   initial begin
      #50000;
      err_count++;
      close_out();
   end
   // ==========
   // tests
   initial begin
      rst = 1'b1;
      {wr, rs, ra, wd} = '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      foreach (tab[i]) rd(tab[i][35:32], tab[i][31:0], "reset");
      wr_reg(4'h0, 32'hFFFFFFF3);
      rd(4'h0, 32'h13, "id");
      tdone("registers");
      fork
         ctl.row({2'b10, 4'h3, 1'b1, 5'd2, 12'h005});
         ctl.col({1'b1, 5'h01, 5'd9, 6'd0, 4'h0, 2'h0, 17'h0}, 1'b0, D1);
      join
      rd(4'hC, 32'h4, "open");
      ctl.row({2'b01, 4'h3, 1'b1, 5'd6, 12'h005});
      rd(4'hC, 32'h4, "foreign");
      ctl.row({2'b10, 4'h3, 1'b1, 5'd3, 12'h005});
      rd(4'hC, 32'h4, "neighbour");
      rd(4'h8, 32'h2, "clash");
      wr_reg(4'h8, 32'h2);
      rd(4'h8, 32'h0, "clash clear");
      tdone("activate");
      ctl.col({1'b1, 5'h13, 5'd2, 6'd7, 4'h1, 2'h0, 17'h1FFFF}, 1'b1, D1);
      rd(4'h8, 32'h1, "buffered");
      ctl.col({1'b1, 5'h13, 5'd2, 6'd7, 4'h2, 2'h0, 17'h0}, 1'b0, D1);
      rd(4'h8, 32'h1, "held");
      ctl.col({1'b1, 5'h13, 5'd2, 6'd0, 4'h0, 2'h0, 17'h1FFFF}, 1'b0, D1);
      rd(4'h8, 32'h0, "retired");
      ctl.col({1'b1, 5'h13, 5'd2, 6'd7, 4'h1, 2'h0, 17'h1FFFF}, 1'b1, D2);
      ctl.col({1'b1, 5'h01, 5'd9, 6'd0, 4'h0, 2'h0, 1'b1, 8'h01, 8'h80}, 1'b0, D1);
      ctl.col({1'b1, 5'h13, 5'd2, 6'd7, 4'hA, 2'h0, 17'h0}, 1'b0, D1);
      repeat (4) @(posedge clk);
      `CHK("read data", DM, rd_q)
      rd(4'hC, 32'h0, "read close");
      tdone("write");
      ctl.row({2'b10, 4'h3, 1'b1, 5'd2, 12'h005});
      ctl.col({1'b1, 5'h13, 5'd2, 6'd7, 4'h2, 2'h0, 1'b0, 5'h13, 5'd2, 5'h01, 1'b0}, 1'b0, D1);
      rd(4'hC, 32'h0, "ext close");
      ctl.row({2'b10, 4'h3, 1'b1, 5'd2, 12'h005});
      ctl.row({2'b10, 4'h3, 1'b0, 5'd2, 12'h001});
      ctl.row({2'b10, 4'h3, 1'b1, 5'd3, 12'h005});
      rd(4'hC, 32'h8, "row close");
      ctl.row({2'b11, 4'h0, 1'b0, 5'd31, 12'h002});
      rd(4'h4, 32'h1, "refresh");
      rd(4'hC, 32'h80000008, "broadcast");
      tdone("precharge");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(4'h0, 32'h0, "id again");
      rd(4'hC, 32'h0, "open again");
      tdone("reset");
      close_out();
   end
endmodule : tb
